// ==== verilog/thal_params.svh ====
`ifndef THAL_PARAMS_SVH
`define THAL_PARAMS_SVH

// ==========================================================
// register indices (pointer values)
`define THAL_REG_TEMP        2'h0
`define THAL_REG_CTL         2'h1
`define THAL_REG_LOWER       2'h2
`define THAL_REG_UPPER       2'h3

// ==========================================================
// control word bit positions
`define THAL_CTL_FLAG        7
`define THAL_CTL_MASK        6
`define THAL_CTL_ZONE        5
`define THAL_CTL_FILT_HI     4
`define THAL_CTL_FILT_LO     3
`define THAL_CTL_SENSE       2
`define THAL_CTL_MODE        1
`define THAL_CTL_PD          0

// ==========================================================
// reset values and full-scale reading
`define THAL_TEMP_RST        9'h000
`define THAL_LOWER_RST       9'h096
`define THAL_UPPER_RST       9'h0a0
`define THAL_FULL_SCALE      9'h0ff

// ==========================================================
// filter depth codes and counts
`define THAL_FILT_1          2'h0
`define THAL_FILT_2          2'h1
`define THAL_FILT_4          2'h2
`define THAL_DEPTH_1         3'h1
`define THAL_DEPTH_2         3'h2
`define THAL_DEPTH_4         3'h4
`define THAL_DEPTH_6         3'h6

// ==========================================================
// timing counts
`define THAL_CONV_LOCAL_CYCLES 16'h07d0
`define THAL_STRAP_WAIT      2'h3

`endif

// ==== verilog/thal_pkg.sv ====
package thal_pkg;

  // ==========================================================
  // conversion sequencer states
  typedef enum logic [1:0] {
    THAL_IDLE = 2'b00,
    THAL_CONV = 2'b01,
    THAL_HALT = 2'b10
  } thal_conv_state_t;

  // ==========================================================
  // core state
  typedef struct packed {
    thal_conv_state_t st;
    logic [15:0]      convCnt;
    logic             convDone;
    logic [8:0]       temp;
    logic [8:0]       lower;
    logic [8:0]       upper;
    logic             flag;
    logic             mask;
    logic             zone;
    logic [1:0]       filt;
    logic             sense;
    logic             mode;
    logic             pd;
    logic [2:0]       overCnt;
    logic [2:0]       underCnt;
    logic             compAct;
    logic             intLatch;
    logic             lookOver;
    logic             wrTogD;
    logic             rdTogD;
    logic [1:0]       strapCnt;
    logic             strapDone;
    logic [2:0]       slaveAddr;
    logic             alertOe;
    logic             alertOut;
    logic [15:0]      rdData;
  } thal_core_t;

  // ==========================================================
  // link side capture state
  typedef struct packed {
    logic        wrTog;
    logic        rdTog;
    logic [1:0]  wrSel;
    logic [15:0] wrData;
  } thal_link_t;

endpackage

// ==== verilog/thal_sync.sv ====
module thal_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } thal_sync_st_t;

  thal_sync_st_t s_r;
  thal_sync_st_t s_nxt;

  // two stage chain, first stage feeds only the second
  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;

endmodule // thal_sync

// ==== verilog/thal_link_port.sv ====
`include "thal_params.svh"

module thal_link_port
  import thal_pkg::*;
(
  // link clock and reset
  input  wire logic        linkClk,
  input  wire logic        linkReset,
  // strobes from the serial engine
  input  wire logic        accWrStb,
  input  wire logic        accRdStb,
  input  wire logic [1:0]  accSel,
  input  wire logic [15:0] accWrData,
  // toward the core domain
  output logic             wrTog,
  output logic             rdTog,
  output logic [1:0]       wrSel,
  output logic [15:0]      wrData
);

  thal_link_t s_r;
  thal_link_t s_nxt;

  // capture write word and flip toggle on the same edge, the core sees the toggle only after sync so data is stable
  always_comb begin
    s_nxt = s_r;
    if (accWrStb) begin
      s_nxt.wrSel  = accSel;
      s_nxt.wrData = accWrData;
      s_nxt.wrTog  = ~s_r.wrTog;
    end
    if (accRdStb) begin
      s_nxt.rdTog = ~s_r.rdTog;
    end
  end

  always_ff @(posedge linkClk) begin
    if (linkReset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wrTog  = s_r.wrTog;
  assign rdTog  = s_r.rdTog;
  assign wrSel  = s_r.wrSel;
  assign wrData = s_r.wrData;

endmodule // thal_link_port

// ==== verilog/thal_supervisor.sv ====
// Function
// - convert continuously unless powered down or addressed by the bus
// - bus access halts conversion and discards partial result
// - after access a fresh conversion starts, result one conversion time later
// - remote zone conversion takes twice the local conversion time
// - straps sampled once after reset, latched as low address bits
// - reset: normal, local zone, comparator, active low, depth one, unmasked, 80/75
// - power-down bit stops conversions, clearing resumes them
// - all registers stay accessible while powered down
// - power-down in comparator behaviour keeps alert unchanged
// - power-down in interrupt behaviour clears alert and flag, keeps direction
// - comparator alert sets over upper, clears under lower, both filtered
// - interrupt alert and flag latch until any read or power-down
// - interrupt behaviour alternates over and under event direction
// - mode cleared then set rearms for an overtemperature event
// - filter field selects 1, 2, 4 or 6 consecutive conversions
// - event is above upper or below lower, unbroken run qualifies
// - control word read clears flag, multiple events give one flag
// - flag set regardless of mask, interrupt only when unmasked
// - sense bit clear gives active low, set gives active high
// - mask bit set forces the alert pin released
// - flag is the top bit, top bits reset zero, first conversion can set
// - values are nine bit two's complement, left justified in 16 bits
// - zone bit picks local or remote, writing restarts conversion
// - remote diode fault forces full scale reading
`include "thal_params.svh"

module thal_supervisor
  import thal_pkg::*;
#(
  parameter logic [15:0] CONV_CYCLES = `THAL_CONV_LOCAL_CYCLES
) (
  // core clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // link clock domain
  input  wire logic        linkClk,
  input  wire logic        linkReset,
  input  wire logic        accBusy,
  input  wire logic        accWrStb,
  input  wire logic        accRdStb,
  input  wire logic [1:0]  accSel,
  input  wire logic [15:0] accWrData,
  output logic      [15:0] rdData,
  // analog front end
  input  wire logic [8:0]  sampleLocal,
  input  wire logic [8:0]  sampleRemote,
  input  wire logic        diodeFault,
  // address straps
  input  wire logic        strap2OrDiodeInput,
  input  wire logic        strapBitOne,
  input  wire logic        strapBitZero,
  output logic      [2:0]  slaveAddrLow,
  // open-drain alert pin
  output logic             alertOut,
  output logic             alertOe
);

  // ==========================================================
  // reset image
  localparam thal_core_t CORE_RST = '{
    st: THAL_IDLE, convCnt: 16'h0000, convDone: 1'b0, temp: `THAL_TEMP_RST,
    lower: `THAL_LOWER_RST, upper: `THAL_UPPER_RST, flag: 1'b0, mask: 1'b0,
    zone: 1'b0, filt: `THAL_FILT_1, sense: 1'b0, mode: 1'b0, pd: 1'b0,
    overCnt: 3'h0, underCnt: 3'h0, compAct: 1'b0, intLatch: 1'b0, lookOver: 1'b1,
    wrTogD: 1'b0, rdTogD: 1'b0, strapCnt: 2'h0, strapDone: 1'b0, slaveAddr: 3'h0,
    alertOe: 1'b0, alertOut: 1'b0, rdData: 16'h0000};

  // ==========================================================
  // helpers
  function automatic logic gt9(input logic [8:0] a, input logic [8:0] b);
    gt9 = $signed(a) > $signed(b);
  endfunction

  function automatic logic [2:0] filt_depth(input logic [1:0] f);
    if (f == `THAL_FILT_1) begin
      filt_depth = `THAL_DEPTH_1;
    end else if (f == `THAL_FILT_2) begin
      filt_depth = `THAL_DEPTH_2;
    end else if (f == `THAL_FILT_4) begin
      filt_depth = `THAL_DEPTH_4;
    end else begin
      filt_depth = `THAL_DEPTH_6;
    end
  endfunction

  function automatic logic [2:0] bump(input logic [2:0] c);
    bump = (c >= `THAL_DEPTH_6) ? `THAL_DEPTH_6 : c + 3'h1;
  endfunction

  function automatic logic [15:0] conv_target(input logic z);
    conv_target = z ? {CONV_CYCLES[14:0], 1'b0} : CONV_CYCLES;
  endfunction

  // ==========================================================
  // link capture and crossing
  logic        lnkWrTog;
  logic        lnkRdTog;
  logic [1:0]  lnkWrSel;
  logic [15:0] lnkWrData;
  logic [26:0] syncIn;
  logic [26:0] syncOut;

  thal_link_port u_link (
    .linkClk   (linkClk),
    .linkReset (linkReset),
    .accWrStb  (accWrStb),
    .accRdStb  (accRdStb),
    .accSel    (accSel),
    .accWrData (accWrData),
    .wrTog     (lnkWrTog),
    .rdTog     (lnkRdTog),
    .wrSel     (lnkWrSel),
    .wrData    (lnkWrData)
  );

  assign syncIn = {accBusy, lnkWrTog, lnkRdTog, accSel, strap2OrDiodeInput, strapBitOne,
                   strapBitZero, sampleLocal, sampleRemote, diodeFault};

  thal_sync #(.W(27)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     (syncIn),
    .q     (syncOut)
  );

  // synchronised views
  logic       busy;
  logic       wrTogS;
  logic       rdTogS;
  logic [1:0] selS;
  logic [2:0] strapS;
  logic [8:0] localS;
  logic [8:0] remoteS;
  logic       faultS;

  assign busy    = syncOut[26];
  assign wrTogS  = syncOut[25];
  assign rdTogS  = syncOut[24];
  assign selS    = syncOut[23:22];
  assign strapS  = syncOut[21:19];
  assign localS  = syncOut[18:10];
  assign remoteS = syncOut[9:1];
  assign faultS  = syncOut[0];

  // ==========================================================
  // core state
  thal_core_t s_r;
  thal_core_t s_nxt;

  logic       wrEv;
  logic       rdEv;
  logic       ctlWr;
  logic       doneNow;
  logic [8:0] smp;
  logic       over;
  logic       under;
  logic       overQ;
  logic       underQ;
  logic       setEv;
  logic       act;
  logic [7:0] ctlByte;

  always_comb begin
    s_nxt    = s_r;
    wrEv     = wrTogS ^ s_r.wrTogD;
    rdEv     = rdTogS ^ s_r.rdTogD;
    ctlWr    = wrEv && (lnkWrSel == `THAL_REG_CTL);
    doneNow  = 1'b0;
    over     = 1'b0;
    under    = 1'b0;
    overQ    = 1'b0;
    underQ   = 1'b0;
    setEv    = 1'b0;
    act      = 1'b0;
    ctlByte  = 8'h00;
    s_nxt.wrTogD   = wrTogS;
    s_nxt.rdTogD   = rdTogS;
    s_nxt.convDone = 1'b0;
    // remote reading pinned to full scale on a diode fault
    smp = s_r.zone ? (faultS ? `THAL_FULL_SCALE : remoteS) : localS;

    // conversion sequencer
    if (s_r.pd) begin
      s_nxt.st      = THAL_IDLE;
      s_nxt.convCnt = 16'h0000;
    end else if (busy) begin
      s_nxt.st      = THAL_HALT;
      s_nxt.convCnt = 16'h0000;
    end else begin
      case (s_r.st)
        THAL_IDLE, THAL_HALT: begin
          s_nxt.st      = THAL_CONV;
          s_nxt.convCnt = 16'h0000;
        end
        THAL_CONV: begin
          if (s_r.convCnt == conv_target(s_r.zone) - 16'h0001) begin
            s_nxt.convCnt  = 16'h0000;
            s_nxt.convDone = 1'b1;
            s_nxt.temp     = smp;
            doneNow        = 1'b1;
          end else begin
            s_nxt.convCnt = s_r.convCnt + 16'h0001;
          end
        end
        default: begin
          s_nxt.st = THAL_IDLE;
        end
      endcase
    end

    // event filter
    if (doneNow) begin
      over           = gt9(smp, s_r.upper);
      under          = gt9(s_r.lower, smp);
      s_nxt.overCnt  = over ? bump(s_r.overCnt) : 3'h0;
      s_nxt.underCnt = under ? bump(s_r.underCnt) : 3'h0;
      overQ          = over && (s_nxt.overCnt >= filt_depth(s_r.filt));
      underQ         = under && (s_nxt.underCnt >= filt_depth(s_r.filt));
    end

    // thermostat level
    if (overQ) begin
      s_nxt.compAct = 1'b1;
    end else if (underQ) begin
      s_nxt.compAct = 1'b0;
    end

    // interrupt direction tracking
    if (s_r.mode) begin
      if (overQ && s_r.lookOver) begin
        setEv          = 1'b1;
        s_nxt.lookOver = 1'b0;
      end else if (underQ && !s_r.lookOver) begin
        setEv          = 1'b1;
        s_nxt.lookOver = 1'b1;
      end
    end else begin
      setEv = overQ || underQ;
    end

    // any read clears, a same cycle event wins
    if (rdEv) begin
      s_nxt.flag     = 1'b0;
      s_nxt.intLatch = 1'b0;
    end
    if (setEv) begin
      s_nxt.flag = 1'b1;
      if (s_r.mode) begin
        s_nxt.intLatch = 1'b1;
      end
    end

    // register writes, accepted in every state
    if (wrEv) begin
      if (lnkWrSel == `THAL_REG_LOWER) begin
        s_nxt.lower = lnkWrData[15:7];
      end else if (lnkWrSel == `THAL_REG_UPPER) begin
        s_nxt.upper = lnkWrData[15:7];
      end else if (lnkWrSel == `THAL_REG_CTL) begin
        s_nxt.mask     = lnkWrData[8 + `THAL_CTL_MASK];
        s_nxt.zone     = lnkWrData[8 + `THAL_CTL_ZONE];
        s_nxt.filt     = lnkWrData[8 + `THAL_CTL_FILT_HI : 8 + `THAL_CTL_FILT_LO];
        s_nxt.sense    = lnkWrData[8 + `THAL_CTL_SENSE];
        s_nxt.mode     = lnkWrData[8 + `THAL_CTL_MODE];
        s_nxt.pd       = lnkWrData[8 + `THAL_CTL_PD];
        s_nxt.overCnt  = 3'h0;
        s_nxt.underCnt = 3'h0;
      end
    end
    if (ctlWr) begin
      s_nxt.convCnt = 16'h0000;
      if (!s_r.mode && lnkWrData[8 + `THAL_CTL_MODE]) begin
        s_nxt.lookOver = 1'b1;
      end
      if (s_r.mode && !s_r.pd && lnkWrData[8 + `THAL_CTL_PD]) begin
        s_nxt.flag     = 1'b0;
        s_nxt.intLatch = 1'b0;
      end
    end

    // strap capture once after reset release
    if (!s_r.strapDone) begin
      if (s_r.strapCnt == `THAL_STRAP_WAIT) begin
        s_nxt.slaveAddr = strapS;
        s_nxt.strapDone = 1'b1;
      end else begin
        s_nxt.strapCnt = s_r.strapCnt + 2'h1;
      end
    end

    // open-drain alert pin from next state
    act            = s_nxt.mode ? s_nxt.intLatch : s_nxt.compAct;
    s_nxt.alertOe  = !s_nxt.mask && (s_nxt.sense ? !act : act);
    s_nxt.alertOut = 1'b0;

    // read data, first byte in the top half
    ctlByte = {s_nxt.flag, s_nxt.mask, s_nxt.zone, s_nxt.filt, s_nxt.sense, s_nxt.mode, s_nxt.pd};
    if (selS == `THAL_REG_TEMP) begin
      s_nxt.rdData = {s_nxt.temp, 7'h00};
    end else if (selS == `THAL_REG_CTL) begin
      s_nxt.rdData = {ctlByte, 8'h00};
    end else if (selS == `THAL_REG_LOWER) begin
      s_nxt.rdData = {s_nxt.lower, 7'h00};
    end else begin
      s_nxt.rdData = {s_nxt.upper, 7'h00};
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= CORE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdData       = s_r.rdData;
  assign slaveAddrLow = s_r.slaveAddr;
  assign alertOut     = s_r.alertOut;
  assign alertOe      = s_r.alertOe;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_pd_no_conv: assert property (
    s_r.convDone |-> !$past(s_r.pd))
    else $error("conversion completed while powered down");

  a_busy_halts: assert property (
    busy |=> (s_r.convCnt == 16'h0000) && !s_r.convDone)
    else $error("conversion ran during bus access");

  a_conv_length: assert property (
    s_r.convDone |-> $past(s_r.convCnt) == conv_target($past(s_r.zone)) - 16'h0001)
    else $error("conversion length wrong for zone");

  a_temp_update: assert property (
    $changed(s_r.temp) |-> s_r.convDone)
    else $error("measured value changed without a finished conversion");

  a_strap_hold: assert property (
    s_r.strapDone && $past(s_r.strapDone) |-> $stable(s_r.slaveAddr))
    else $error("address straps resampled");

  a_mask_release: assert property (
    s_r.mask |-> !alertOe)
    else $error("alert driven while masked");

  a_flag_sticky: assert property (
    $past(s_r.flag) && !$past(rdEv) && !$past(ctlWr) |-> s_r.flag)
    else $error("event flag dropped without read");

  a_pd_clears: assert property (
    $past(ctlWr) && $past(s_r.mode) && !$past(s_r.pd) && s_r.pd |-> !s_r.flag && !s_r.intLatch)
    else $error("power-down in interrupt behaviour left flag set");

  a_comp_keep: assert property (
    !s_r.mode && s_r.pd && $past(s_r.pd) && $past(!s_r.mode) |-> $stable(s_r.compAct))
    else $error("thermostat level changed in power-down");

  a_sense_sel: assert property (
    !s_r.mask && !s_r.mode |-> alertOe == (s_r.sense ^ s_r.compAct))
    else $error("alert sense wrong");

  a_reset_vals: assert property (
    $fell(reset) |-> (s_r.upper == `THAL_UPPER_RST) && (s_r.lower == `THAL_LOWER_RST) && !s_r.mode && !s_r.pd)
    else $error("reset values wrong");

endmodule // thal_supervisor

// ==== testbench/thal_host_model.sv ====
module thal_host_model (
  // link clock and reset
  output logic             linkClk,
  output logic             linkReset,
  // register access toward the device
  output logic             accBusy,
  output logic             accWrStb,
  output logic             accRdStb,
  output logic      [1:0]  accSel,
  output logic      [15:0] accWrData,
  // read data from the device
  input  wire logic [15:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;

  logic run;

  // ==========================================================
  // link clock, parked low between frames
  initial begin
    {linkClk, linkReset, accBusy, accWrStb, accRdStb, accSel, accWrData, run} = {2'h1, 5'h00, 16'h0000, 1'b1};
    #3;
    forever begin
      #80;
      if (run || linkClk) linkClk = ~linkClk;
    end
  end

  // link reset over the first link edges, then clock stops
  initial begin
    repeat (4) @(posedge linkClk);
    linkReset <= 1'b0;
    @(negedge linkClk);
    run = 1'b0;
  end

  // one access frame: busy, select, hold, then a write or read strobe
  task automatic frame(input logic wr, input logic [1:0] sel, input logic [15:0] wd, input int hold,
                       output logic [15:0] rd);
    run = 1'b1;
    @(posedge linkClk);
    accBusy   <= 1'b1;
    accSel    <= sel;
    accWrData <= wd;
    repeat (hold) @(posedge linkClk);
    rd = rdData;
    accWrStb <= wr;
    accRdStb <= ~wr;
    @(posedge linkClk);
    {accBusy, accWrStb, accRdStb} <= 3'h0;
    accWrData <= ~wd;  // released data no longer shows the last word
    @(negedge linkClk);
    run = 1'b0;
  endtask
endmodule // thal_host_model

// ==== testbench/tb_thermal_alarm_supervisor.sv ====
`include "thal_params.svh"

module tb_thermal_alarm_supervisor;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  logic        clk;
  logic        reset;
  logic        linkClk;
  logic        linkReset;
  logic        accBusy;
  logic        accWrStb;
  logic        accRdStb;
  logic [1:0]  accSel;
  logic [15:0] accWrData;
  logic [15:0] rdData;
  logic [8:0]  sampleLocal;
  logic [8:0]  sampleRemote;
  logic        diodeFault;
  logic        strap2OrDiodeInput;
  logic        strapBitOne;
  logic        strapBitZero;
  logic [2:0]  slaveAddrLow;
  logic        alertOut;
  logic        alertOe;
  int          nMismatch;
  int          checked;
  int          dep[4] = '{1, 2, 4, 6};

  // ==========================================================
  // design and host
  thal_supervisor #(.CONV_CYCLES(16'h0010)) dut (
    .clk(clk), .reset(reset), .linkClk(linkClk), .linkReset(linkReset), .accBusy(accBusy),
    .accWrStb(accWrStb), .accRdStb(accRdStb), .accSel(accSel), .accWrData(accWrData), .rdData(rdData),
    .sampleLocal(sampleLocal), .sampleRemote(sampleRemote), .diodeFault(diodeFault),
    .strap2OrDiodeInput(strap2OrDiodeInput), .strapBitOne(strapBitOne), .strapBitZero(strapBitZero),
    .slaveAddrLow(slaveAddrLow), .alertOut(alertOut), .alertOe(alertOe));

  thal_host_model host (
    .linkClk(linkClk), .linkReset(linkReset), .accBusy(accBusy), .accWrStb(accWrStb),
    .accRdStb(accRdStb), .accSel(accSel), .accWrData(accWrData), .rdData(rdData));

  // core clock
  always #12.5 clk = ~clk;

  // ==========================================================
  // helpers
  // sample just after the edge, once the design's flops have settled
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    #1;
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    #1;
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // new sensor reading for the local zone
  task automatic tmp(input logic [8:0] t);
    @(posedge clk);
    sampleLocal <= t;
  endtask

  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    logic [15:0] v;
    host.frame(1'b1, s, d, 1, v);
    wt(8);
  endtask

  task automatic rd(input logic [1:0] s, input logic [15:0] e);
    logic [15:0] v;
    host.frame(1'b0, s, 16'h0000, 1, v);
    cmp_word(v, e);
    wt(8);
  endtask

  task automatic print_verdict();
    if (nMismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // 25 degrees sits below the 75 degree lower threshold, so the first conversion flags an event
  task automatic t_defaults();
    wt(40);
    cmp_word({13'h0, slaveAddrLow}, 16'h0005);
    rd(`THAL_REG_CTL, 16'h8000);
    rd(`THAL_REG_LOWER, 16'h4b00);
    rd(`THAL_REG_UPPER, 16'h5000);
    rd(`THAL_REG_TEMP, 16'h1900);
    cmp_bit(alertOe, 1'b0);
  endtask

  task automatic t_powerdown();
    wr(`THAL_REG_CTL, 16'h0100);
    tmp(9'h064);
    wr(`THAL_REG_LOWER, 16'he700);
    wr(`THAL_REG_UPPER, 16'h7f80);
    wr(`THAL_REG_TEMP, 16'h1234);
    rd(`THAL_REG_LOWER, 16'he700);
    rd(`THAL_REG_UPPER, 16'h7f80);
    rd(`THAL_REG_CTL, 16'h0100);
    wt(100);
    rd(`THAL_REG_TEMP, 16'h1900);
    wr(`THAL_REG_LOWER, 16'h4b00);
    wr(`THAL_REG_UPPER, 16'h5000);
    wr(`THAL_REG_CTL, 16'h0000);
    wt(40);
    rd(`THAL_REG_TEMP, 16'h3200);
  endtask

  task automatic t_busy();
    logic [15:0] v;
    fork
      host.frame(1'b0, `THAL_REG_TEMP, 16'h0000, 20, v);
      begin
        wt(40);
        tmp(9'h070);
      end
    join
    cmp_word(v, 16'h3200);
    rd(`THAL_REG_TEMP, 16'h3200);
    wt(30);
    rd(`THAL_REG_TEMP, 16'h3800);
  endtask

  // comparator filter depth for each field code
  task automatic t_filter();
    for (int f = 0; f < 4; f++) begin
      wr(`THAL_REG_CTL, {3'h0, f[1:0], 11'h000});
      tmp(9'h0aa);
      wt(16 * dep[f] - 14);
      cmp_bit(alertOe, 1'b0);
      wt(14);
      cmp_bit(alertOe, 1'b1);
      tmp(9'h09b);
      wt(120);
      cmp_bit(alertOe, 1'b1);
      tmp(9'h000);
      wt(16 * dep[f] + 24);
      cmp_bit(alertOe, 1'b0);
    end
  endtask

  task automatic t_pins();
    wr(`THAL_REG_CTL, 16'h0000);
    tmp(9'h0aa);
    wt(40);
    cmp_bit(alertOe, 1'b1);
    cmp_bit(alertOut, 1'b0);
    wr(`THAL_REG_CTL, 16'h0400);
    cmp_bit(alertOe, 1'b0);
    wr(`THAL_REG_CTL, 16'h0100);
    tmp(9'h000);
    wt(100);
    cmp_bit(alertOe, 1'b1);
    wr(`THAL_REG_CTL, 16'h4100);
    cmp_bit(alertOe, 1'b0);
    wr(`THAL_REG_CTL, 16'h0000);
    wt(40);
    cmp_bit(alertOe, 1'b0);
  endtask

  task automatic t_int();
    tmp(9'h09b);
    wr(`THAL_REG_CTL, 16'h0200);
    rd(`THAL_REG_CTL, 16'h8200);
    tmp(9'h0aa);
    wt(40);
    cmp_bit(alertOe, 1'b1);
    tmp(9'h09b);
    wt(60);
    cmp_bit(alertOe, 1'b1);
    rd(`THAL_REG_CTL, 16'h8200);
    rd(`THAL_REG_TEMP, 16'h4d80);
    cmp_bit(alertOe, 1'b0);
    tmp(9'h0aa);
    wt(80);
    cmp_bit(alertOe, 1'b0);
    wr(`THAL_REG_CTL, 16'h0000);
    wr(`THAL_REG_CTL, 16'h0200);
    wt(40);
    cmp_bit(alertOe, 1'b1);
    rd(`THAL_REG_CTL, 16'h8200);
    tmp(9'h000);
    wt(40);
    cmp_bit(alertOe, 1'b1);
    wr(`THAL_REG_CTL, 16'h4200);
    cmp_bit(alertOe, 1'b0);
    rd(`THAL_REG_CTL, 16'hc200);
    tmp(9'h0aa);
    wt(40);
    cmp_bit(alertOe, 1'b0);
    rd(`THAL_REG_CTL, 16'hc200);
    wr(`THAL_REG_CTL, 16'h0200);
    tmp(9'h000);
    wt(40);
    cmp_bit(alertOe, 1'b1);
    wr(`THAL_REG_CTL, 16'h0300);
    cmp_bit(alertOe, 1'b0);
    rd(`THAL_REG_CTL, 16'h0300);
    wr(`THAL_REG_CTL, 16'h0200);
    wt(60);
    cmp_bit(alertOe, 1'b0);
  endtask

  task automatic t_remote();
    wr(`THAL_REG_CTL, 16'h2000);
    wt(16);
    cmp_bit(alertOe, 1'b0);
    wt(14);
    cmp_bit(alertOe, 1'b1);
    rd(`THAL_REG_TEMP, 16'h5500);
    @(posedge clk);
    diodeFault   <= 1'b1;
    sampleRemote <= 9'h000;
    wt(80);
    rd(`THAL_REG_TEMP, 16'h7f80);
    cmp_bit(alertOe, 1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {clk, reset, diodeFault, strap2OrDiodeInput, strapBitOne, strapBitZero} = 6'b010101;
    sampleLocal  = 9'h032;
    sampleRemote = 9'h0aa;
    nMismatch    = 0;
    checked      = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_defaults();
    t_powerdown();
    t_busy();
    t_filter();
    t_pins();
    t_int();
    t_remote();
    print_verdict();
  end

  // watchdog against a hang
  initial begin
    #1000000;
    nMismatch++;
    print_verdict();
  end
endmodule // tb_thermal_alarm_supervisor
